// file: src/spdf_top.sv
// Purpose: Serial port with delimiter-gated forwarding toward the network side
// Assumes: One 200 MHz clock; serial pins asynchronous; network side on REF_CLK
// Notes:   Settings on CFG are sampled only in the cycle after any reset
// Behaviour
// - Bit rate chosen from eleven rates
// - Five to eight data bits per character
// - Parity none, odd, even, space or mark
// - One, one and half, two stops
// - Flow control on, or no handshake gating
// - Count bytes lost to full network cache
// - Count receive buffer overflow events separately
// - Two delimiters gate release of cached bytes
// - Silence for set 200 ms steps drops connection
// - Optionally strip the delimiter byte
// - New settings apply only after reset
// - Reset command forces full device reset
`timescale 1ns/1ps
module spdf_top
	import spdf_pkg::*;
#(
	parameter int unsigned RXF_DEPTH       = 16,
	parameter int unsigned CACHE_DEPTH     = 64,
	parameter int unsigned CNT_W           = 32,
	parameter int unsigned RTS_MARGIN      = 4,
	parameter int unsigned SILENT_STEP_CYC = spdf_pkg::SPDF_SILENT_STEP_CYC
) (
	input  wire logic               REF_CLK,
	input  wire logic               RST_N,
	input  wire spdf_pkg::spdf_cfg_s CFG,
	input  wire logic               RESET_CMD,
	input  wire logic               RXD,
	input  wire logic               CTS_N,
	output logic                    TXD,
	output logic                    RTS_N,
	input  wire logic [7:0]         NET_TX_DATA,
	input  wire logic               NET_TX_VALID,
	output logic                    NET_TX_READY,
	output logic [7:0]              NET_RX_DATA,
	output logic                    NET_RX_VALID,
	input  wire logic               NET_RX_READY,
	output logic [CNT_W-1:0]        MEM_OVF_CNT,
	output logic [CNT_W-1:0]        FIFO_OVF_CNT,
	output logic                    DROP_CONN,
	output spdf_pkg::spdf_sts_s     STATUS
);
	import spdf_pkg::*;

	localparam int unsigned RW = $clog2(RXF_DEPTH);
	localparam int unsigned CW = $clog2(CACHE_DEPTH);

	logic                  rst_cmd_r;   // Reset command seen last cycle
	logic                  srst_n;      // Internal reset, low active
	logic                  load_r;      // First cycle after reset
	spdf_cfg_s             cfg_r;       // Settings in force
	logic [SPDF_DIV_W-1:0] div_cnt_r;   // Baud divider count
	logic                  tick_r;      // Oversample enable pulse
	logic                  rxd_s;       // Synchronised receive pin
	logic                  cts_n_s;     // Synchronised clear-to-send
	logic                  cts_ok;      // Transmit permitted
	logic [2:0]            last_bit;    // Index of last data bit
	spdf_st_e              rx_st_r;     // Receive state
	logic [4:0]            rx_tk_r;     // Receive tick in bit
	logic [2:0]            rx_bit_r;    // Receive data bit index
	logic [7:0]            rx_sh_r;     // Receive shifter
	logic                  rx_pb_r;     // Received parity bit
	logic [7:0]            rx_al;       // Aligned received data
	logic                  rx_push_r;   // Byte ready for buffer
	logic [7:0]            rx_byte_r;   // Byte toward buffer
	logic                  par_err_r;   // Last frame parity bad
	logic                  frm_err_r;   // Last frame stop bad
	logic                  rxf_wr_rdy;  // Receive buffer has room
	logic                  rxf_rd_v;    // Receive buffer not empty
	logic                  rxf_pop;     // Take head of buffer
	logic [7:0]            rxf_head;    // Head byte
	logic [RW:0]           rxf_cnt;     // Receive buffer level
	logic                  c_wr_v;      // Write into cache
	logic                  c_wr_rdy;    // Cache has room
	logic                  c_rd_v;      // Cache not empty
	logic                  c_pop;       // Read from cache
	logic [7:0]            c_head;      // Cache head byte
	logic                  delim_mode;  // Any delimiter enabled
	logic                  is_delim;    // Head matches a delimiter
	logic                  drop_it;     // Head stripped
	logic                  lose;        // Head discarded for lack of space
	logic                  mv;          // Head leaves receive buffer
	logic                  c_wr;        // Cache write accepted
	logic [CW:0]           rel_cnt_r;   // Cached bytes cleared for sending
	logic [CW:0]           unrel_r;     // Cached bytes awaiting a delimiter
	logic [CW:0]           rel_add;     // Bytes cleared this cycle
	logic                  net_v_r;     // Network output valid
	logic [7:0]            net_d_r;     // Network output data
	spdf_st_e              tx_st_r;     // Transmit state
	logic [5:0]            tx_tk_r;     // Transmit tick in bit
	logic [2:0]            tx_bit_r;    // Transmit data bit index
	logic [7:0]            tx_sh_r;     // Transmit shifter
	logic                  tx_pb_r;     // Parity bit to send
	logic                  tx_take;     // Network byte accepted
	logic                  txd_r;       // Serial output
	logic                  tx_rdy_r;    // Ready toward network
	logic                  rts_n_r;     // Request-to-send pin
	logic [31:0]           step_cnt_r;  // Cycles inside one silent step
	logic [7:0]            steps_r;     // Silent steps elapsed
	logic [7:0]            steps_lim;   // Steps that end the link
	logic                  drop_r;      // Connection drop pulse
	logic [CNT_W-1:0]      mem_ovf_r;   // Network-buffer loss count
	logic [CNT_W-1:0]      fifo_ovf_r;  // Receive-buffer overflow count
	spdf_sts_s             sts_r;       // Status flags

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			rst_cmd_r <= 1'b0;
		end else begin
			rst_cmd_r <= RESET_CMD;
		end
	end
	assign srst_n = RST_N && !rst_cmd_r;

	// Settings load once per reset; later CFG changes are held off
	always_ff @(posedge REF_CLK) begin
		if (!srst_n) begin
			cfg_r  <= SPDF_CFG_RST;
			load_r <= 1'b1;
		end else begin
			load_r <= 1'b0;
			if (load_r) begin
				cfg_r <= CFG;
			end
		end
	end

	// Oversample tick from the selected rate
	always_ff @(posedge REF_CLK) begin
		if (!srst_n) begin
			div_cnt_r <= '0;
			tick_r    <= 1'b0;
		end else begin
			tick_r <= (div_cnt_r == spdf_baud_div(cfg_r.baud_sel) - 1'b1);
			if (div_cnt_r >= spdf_baud_div(cfg_r.baud_sel) - 1'b1) begin
				div_cnt_r <= '0;
			end else begin
				div_cnt_r <= div_cnt_r + 1'b1;
			end
		end
	end

	// Pin synchronisers; idle levels are mark and CTS deasserted
	spdf_sync #(.RST_VAL(1'b1)) u_sync_rxd (
		.clk   (REF_CLK),
		.rst_n (srst_n),
		.d     (RXD),
		.q     (rxd_s)
	);
	spdf_sync #(.RST_VAL(1'b1)) u_sync_cts (
		.clk   (REF_CLK),
		.rst_n (srst_n),
		.d     (CTS_N),
		.q     (cts_n_s)
	);

	assign last_bit = SPDF_MIN_LAST + {1'b0, cfg_r.char_len};
	// Shifter fills from the top, so short characters need moving down
	assign rx_al    = rx_sh_r >> (2'h3 - cfg_r.char_len);

	// Receive frame machine, mid-bit sampling
	always_ff @(posedge REF_CLK) begin
		if (!srst_n) begin
			rx_st_r   <= SPDF_ST_IDLE;
			rx_tk_r   <= '0;
			rx_bit_r  <= '0;
			rx_sh_r   <= '0;
			rx_pb_r   <= 1'b0;
			rx_push_r <= 1'b0;
			rx_byte_r <= '0;
			par_err_r <= 1'b0;
			frm_err_r <= 1'b0;
		end else begin
			rx_push_r <= 1'b0;
			if (tick_r) begin
				rx_tk_r <= rx_tk_r + 1'b1;
				unique case (rx_st_r)
					SPDF_ST_IDLE: begin
						rx_tk_r <= '0;
						if (!rxd_s) begin
							rx_st_r <= SPDF_ST_START;
						end
					end
					SPDF_ST_START: begin
						// Glitch shorter than half a bit is ignored
						if (rx_tk_r == SPDF_TK_MID) begin
							rx_tk_r  <= '0;
							rx_bit_r <= '0;
							rx_st_r  <= rxd_s ? SPDF_ST_IDLE : SPDF_ST_DATA;
						end
					end
					SPDF_ST_DATA: begin
						if (rx_tk_r == SPDF_TK_END) begin
							rx_tk_r  <= '0;
							rx_sh_r  <= {rxd_s, rx_sh_r[7:1]};
							rx_bit_r <= rx_bit_r + 1'b1;
							if (rx_bit_r == last_bit) begin
								rx_st_r <= (cfg_r.parity == SPDF_PAR_NONE) ? SPDF_ST_STOP : SPDF_ST_PAR;
							end
						end
					end
					SPDF_ST_PAR: begin
						if (rx_tk_r == SPDF_TK_END) begin
							rx_tk_r <= '0;
							rx_pb_r <= rxd_s;
							rx_st_r <= SPDF_ST_STOP;
						end
					end
					SPDF_ST_STOP: begin
						if (rx_tk_r == SPDF_TK_END) begin
							rx_st_r   <= SPDF_ST_IDLE;
							frm_err_r <= !rxd_s;
							par_err_r <= (cfg_r.parity != SPDF_PAR_NONE) &&
								(rx_pb_r != spdf_par_bit(rx_al, cfg_r.char_len, cfg_r.parity));
							// Framing errors are not forwarded
							rx_push_r <= rxd_s;
							rx_byte_r <= rx_al;
						end
					end
					default: begin
						rx_st_r <= SPDF_ST_IDLE;
					end
				endcase
			end
		end
	end

	// Receive buffer between the line and the cache
	spdf_fifo #(.W(8), .DEPTH(RXF_DEPTH)) u_rx_fifo (
		.clk      (REF_CLK),
		.rst_n    (srst_n),
		.wr_valid (rx_push_r),
		.wr_ready (rxf_wr_rdy),
		.wr_data  (rx_byte_r),
		.rd_valid (rxf_rd_v),
		.rd_ready (rxf_pop),
		.rd_data  (rxf_head),
		.count    (rxf_cnt)
	);

	assign delim_mode = cfg_r.delim1_en || cfg_r.delim2_en;
	assign is_delim   = (cfg_r.delim1_en && (rxf_head == cfg_r.delim1)) ||
		(cfg_r.delim2_en && (rxf_head == cfg_r.delim2));
	assign drop_it    = is_delim && cfg_r.drop_en;
	assign lose       = delim_mode && !c_wr_rdy && (rel_cnt_r == '0) && !drop_it;
	// Otherwise a full cache stalls the buffer, so the buffer can overflow
	assign rxf_pop    = rxf_rd_v && (drop_it || lose || c_wr_rdy);
	assign mv         = rxf_pop;
	assign c_wr_v     = rxf_rd_v && !drop_it && !lose;
	assign c_wr       = c_wr_v && c_wr_rdy;
	assign rel_add    = !delim_mode ? (CW+1)'(c_wr) :
		((mv && is_delim) ? unrel_r + (CW+1)'(c_wr) : '0);
	assign c_pop      = c_rd_v && (rel_cnt_r != '0) && (!net_v_r || NET_RX_READY);

	// Cache toward the network
	spdf_fifo #(.W(8), .DEPTH(CACHE_DEPTH)) u_cache (
		.clk      (REF_CLK),
		.rst_n    (srst_n),
		.wr_valid (c_wr_v),
		.wr_ready (c_wr_rdy),
		.wr_data  (rxf_head),
		.rd_valid (c_rd_v),
		.rd_ready (c_pop),
		.rd_data  (c_head),
		.count    ()
	);

	// Release bookkeeping
	always_ff @(posedge REF_CLK) begin
		if (!srst_n) begin
			rel_cnt_r <= '0;
			unrel_r   <= '0;
		end else begin
			rel_cnt_r <= rel_cnt_r + rel_add - (CW+1)'(c_pop);
			if (mv && is_delim) begin
				unrel_r <= '0;
			end else if (delim_mode && c_wr) begin
				unrel_r <= unrel_r + 1'b1;
			end
		end
	end

	// Network output register
	always_ff @(posedge REF_CLK) begin
		if (!srst_n) begin
			net_v_r <= 1'b0;
			net_d_r <= '0;
		end else if (c_pop) begin
			net_v_r <= 1'b1;
			net_d_r <= c_head;
		end else if (NET_RX_READY) begin
			net_v_r <= 1'b0;
		end
	end

	// Loss and overflow counters
	always_ff @(posedge REF_CLK) begin
		if (!srst_n) begin
			mem_ovf_r  <= '0;
			fifo_ovf_r <= '0;
		end else begin
			if (rxf_rd_v && lose) begin
				mem_ovf_r <= mem_ovf_r + 1'b1;
			end
			if (rx_push_r && !rxf_wr_rdy) begin
				fifo_ovf_r <= fifo_ovf_r + 1'b1;
			end
		end
	end

	assign cts_ok  = !cfg_r.flow_en || !cts_n_s;
	assign tx_take = tx_rdy_r && NET_TX_VALID;

	// Transmit frame machine; a byte is only accepted while CTS permits
	always_ff @(posedge REF_CLK) begin
		if (!srst_n) begin
			tx_st_r  <= SPDF_ST_IDLE;
			tx_tk_r  <= '0;
			tx_bit_r <= '0;
			tx_sh_r  <= '0;
			tx_pb_r  <= 1'b0;
			txd_r    <= 1'b1;
			tx_rdy_r <= 1'b0;
		end else if (tx_st_r == SPDF_ST_IDLE) begin
			// Pause while CTS deasserted; the reset-default settings never open the port
			tx_rdy_r <= cts_ok && !tx_take && !load_r;
			if (tx_take) begin
				tx_sh_r  <= NET_TX_DATA;
				tx_pb_r  <= spdf_par_bit(NET_TX_DATA, cfg_r.char_len, cfg_r.parity);
				tx_tk_r  <= '0;
				tx_bit_r <= '0;
				txd_r    <= 1'b0;
				tx_st_r  <= SPDF_ST_START;
			end
		end else if (tick_r) begin
			tx_tk_r <= tx_tk_r + 1'b1;
			unique case (tx_st_r)
				SPDF_ST_START: begin
					if (tx_tk_r[4:0] == SPDF_TK_END) begin
						tx_tk_r <= '0;
						txd_r   <= tx_sh_r[0];
						tx_st_r <= SPDF_ST_DATA;
					end
				end
				SPDF_ST_DATA: begin
					if (tx_tk_r[4:0] == SPDF_TK_END) begin
						tx_tk_r  <= '0;
						tx_sh_r  <= tx_sh_r >> 1;
						tx_bit_r <= tx_bit_r + 1'b1;
						txd_r    <= tx_sh_r[1];
						if (tx_bit_r == last_bit) begin
							txd_r   <= (cfg_r.parity == SPDF_PAR_NONE) ? 1'b1 : tx_pb_r;
							tx_st_r <= (cfg_r.parity == SPDF_PAR_NONE) ? SPDF_ST_STOP : SPDF_ST_PAR;
						end
					end
				end
				SPDF_ST_PAR: begin
					if (tx_tk_r[4:0] == SPDF_TK_END) begin
						tx_tk_r <= '0;
						txd_r   <= 1'b1;
						tx_st_r <= SPDF_ST_STOP;
					end
				end
				SPDF_ST_STOP: begin
					if (tx_tk_r == ((cfg_r.stop == SPDF_STOP_2) ? SPDF_STOP2_END :
						(cfg_r.stop == SPDF_STOP_1P5) ? SPDF_STOP15_END : SPDF_STOP1_END)) begin
						tx_st_r <= SPDF_ST_IDLE;
					end
				end
				default: begin
					tx_st_r <= SPDF_ST_IDLE;
					txd_r   <= 1'b1;
				end
			endcase
		end
	end

	// Request-to-send: held asserted when flow control is off
	always_ff @(posedge REF_CLK) begin
		if (!srst_n) begin
			rts_n_r <= 1'b1;
		end else begin
			rts_n_r <= cfg_r.flow_en && (rxf_cnt >= (RW+1)'(RXF_DEPTH - RTS_MARGIN));
		end
	end

	// Zero means the shortest setting rather than an instant drop
	assign steps_lim = (cfg_r.silent_steps == 8'h00) ? 8'h01 : cfg_r.silent_steps;

	// Silent-time watchdog; any byte either way restarts it
	always_ff @(posedge REF_CLK) begin
		if (!srst_n) begin
			step_cnt_r <= '0;
			steps_r    <= '0;
			drop_r     <= 1'b0;
		end else begin
			drop_r <= 1'b0;
			if (!cfg_r.silent_en || mv || tx_take) begin
				step_cnt_r <= '0;
				steps_r    <= '0;
			end else if (step_cnt_r == 32'(SILENT_STEP_CYC - 1)) begin
				step_cnt_r <= '0;
				if (steps_r + 1'b1 == steps_lim) begin
					steps_r <= '0;
					drop_r  <= 1'b1;
				end else begin
					steps_r <= steps_r + 1'b1;
				end
			end else begin
				step_cnt_r <= step_cnt_r + 1'b1;
			end
		end
	end

	// Status flags register
	always_ff @(posedge REF_CLK) begin
		if (!srst_n) begin
			sts_r <= '0;
		end else begin
			sts_r <= '{par_err: par_err_r, frm_err: frm_err_r,
				rx_fifo_full: !rxf_wr_rdy, cache_full: !c_wr_rdy};
		end
	end

	assign TXD          = txd_r;
	assign RTS_N        = rts_n_r;
	assign NET_TX_READY = tx_rdy_r;
	assign NET_RX_DATA  = net_d_r;
	assign NET_RX_VALID = net_v_r;
	assign MEM_OVF_CNT  = mem_ovf_r;
	assign FIFO_OVF_CNT = fifo_ovf_r;
	assign DROP_CONN    = drop_r;
	assign STATUS       = sts_r;
endmodule

// file: include/spdf_pkg.sv
// Purpose: Shared constants, types and helpers of the serial delimiter forwarder
// Assumes: 200 MHz reference clock, 16x receive oversampling
// Notes:   Baud divisors are derived from the clock rate, never typed in by hand
package spdf_pkg;

	// Clock and oversampling
	localparam int unsigned SPDF_CLK_HZ         = 200_000_000;
	localparam int unsigned SPDF_OVS            = 16;
	localparam int unsigned SPDF_DIV_W          = 17;
	// Silent-time step, in ms and in cycles
	localparam int unsigned SPDF_SILENT_STEP_MS  = 200;
	localparam int unsigned SPDF_SILENT_STEP_CYC = SPDF_CLK_HZ / 1000 * SPDF_SILENT_STEP_MS;

	// Selectable bit rates, index is the baud select code
	localparam int unsigned SPDF_BAUD_N = 11;
	localparam int unsigned SPDF_BAUD_TAB [0:10] = '{110, 300, 1200, 2400, 4800, 9600,
		19200, 38400, 57600, 115200, 230400};
	localparam logic [3:0]  SPDF_BAUD_RST = 4'h8;

	// Tick positions inside one bit
	localparam logic [4:0] SPDF_TK_MID = 5'(SPDF_OVS / 2 - 1);
	localparam logic [4:0] SPDF_TK_END = 5'(SPDF_OVS - 1);
	// Last tick of the stop period for 1, 1.5 and 2 stop bits
	localparam logic [5:0] SPDF_STOP1_END  = 6'(SPDF_OVS - 1);
	localparam logic [5:0] SPDF_STOP15_END = 6'(SPDF_OVS * 3 / 2 - 1);
	localparam logic [5:0] SPDF_STOP2_END  = 6'(SPDF_OVS * 2 - 1);
	// Index of the last data bit for a 5-bit character
	localparam logic [2:0] SPDF_MIN_LAST = 3'h4;

	// Parity settings
	typedef enum logic [2:0] {
		SPDF_PAR_NONE  = 3'b000,
		SPDF_PAR_ODD   = 3'b001,
		SPDF_PAR_EVEN  = 3'b010,
		SPDF_PAR_SPACE = 3'b011,
		SPDF_PAR_MARK  = 3'b100
	} spdf_par_e;

	// Stop lengths
	typedef enum logic [1:0] {
		SPDF_STOP_1   = 2'b00,
		SPDF_STOP_1P5 = 2'b01,
		SPDF_STOP_2   = 2'b10
	} spdf_stop_e;

	// Serial frame states, shared by both directions
	typedef enum logic [2:0] {
		SPDF_ST_IDLE  = 3'b000,
		SPDF_ST_START = 3'b001,
		SPDF_ST_DATA  = 3'b010,
		SPDF_ST_PAR   = 3'b011,
		SPDF_ST_STOP  = 3'b100
	} spdf_st_e;

	// Port configuration; char_len 0..3 means 5..8 data bits
	typedef struct packed {
		logic [3:0] baud_sel;
		logic [1:0] char_len;
		spdf_par_e  parity;
		spdf_stop_e stop;
		logic       flow_en;
		logic       delim1_en;
		logic [7:0] delim1;
		logic       delim2_en;
		logic [7:0] delim2;
		logic       silent_en;
		logic [7:0] silent_steps;
		logic       drop_en;
	} spdf_cfg_s;

	// Settings in force after reset until the stored ones are loaded
	localparam spdf_cfg_s SPDF_CFG_RST = '{baud_sel: SPDF_BAUD_RST, char_len: 2'h3,
		parity: SPDF_PAR_NONE, stop: SPDF_STOP_1, flow_en: 1'b0, delim1_en: 1'b0,
		delim1: 8'h00, delim2_en: 1'b0, delim2: 8'hFF, silent_en: 1'b0,
		silent_steps: 8'h05, drop_en: 1'b0};

	// Status flags
	typedef struct packed {
		logic par_err;
		logic frm_err;
		logic rx_fifo_full;
		logic cache_full;
	} spdf_sts_s;

	// Clock cycles per oversample tick
	function automatic logic [SPDF_DIV_W-1:0] spdf_baud_div(input logic [3:0] sel);
		int unsigned r;
		r = (sel < 4'(SPDF_BAUD_N)) ? SPDF_BAUD_TAB[sel] : SPDF_BAUD_TAB[SPDF_BAUD_RST];
		return SPDF_DIV_W'(SPDF_CLK_HZ / (SPDF_OVS * r));
	endfunction

	// Parity bit over the used data bits
	function automatic logic spdf_par_bit(input logic [7:0] d, input logic [1:0] len, input spdf_par_e p);
		logic x;
		x = ^(d & (8'hFF >> (2'h3 - len)));
		case (p)
			SPDF_PAR_ODD:  return ~x;
			SPDF_PAR_EVEN: return x;
			SPDF_PAR_MARK: return 1'b1;
			default:       return 1'b0;
		endcase
	endfunction

endpackage

// file: src/spdf_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Input is asynchronous to clk
// Notes:   Output only moves when stages two and three agree
`timescale 1ns/1ps
module spdf_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic d,
	output logic      q
);
	logic s1_r; // Metastable stage, read only by s2_r
	logic s2_r; // Second stage
	logic s3_r; // Third stage

	// Shift chain
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Accept a level once two stages agree
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= RST_VAL;
		end else if (s2_r == s3_r) begin
			q <= s3_r;
		end
	end
endmodule

// file: src/spdf_fifo.sv
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: Single clock
// Notes:   Write is ignored while wr_ready is low
`timescale 1ns/1ps
module spdf_fifo #(
	parameter int unsigned W     = 8,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   wr_valid,
	output logic                        wr_ready,
	input  wire logic [W-1:0]           wr_data,
	output logic                        rd_valid,
	input  wire logic                   rd_ready,
	output logic [W-1:0]                rd_data,
	output logic [$clog2(DEPTH):0]      count
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [W-1:0]  mem_r [DEPTH]; // Storage
	logic [AW-1:0] wp_r;          // Write index
	logic [AW-1:0] rp_r;          // Read index
	logic [AW:0]   cnt_r;         // Fill level
	logic          wr;            // Write accepted
	logic          rd;            // Read accepted

	assign wr_ready = (cnt_r != (AW+1)'(DEPTH));
	assign rd_valid = (cnt_r != '0);
	assign rd_data  = mem_r[rp_r];
	assign count    = cnt_r;
	assign wr       = wr_valid && wr_ready;
	assign rd       = rd_valid && rd_ready;

	// Storage write
	always_ff @(posedge clk) begin
		if (wr) begin
			mem_r[wp_r] <= wr_data;
		end
	end

	// Pointers and level; indices wrap at DEPTH
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (wr) begin
				wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
			end
			if (rd) begin
				rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
		end
	end
endmodule

// file: verif/spdf_top_properties.sv
// Purpose: Port-level checks of spdf_top
// Assumes: CFG only changes ahead of a reset
// Notes:   Overflow counting is checked by the bench only
`timescale 1ns/1ps
module spdf_top_properties
	import spdf_pkg::*;
#(
	parameter int unsigned CNT_W = 32
) (
	input wire logic		REF_CLK,
	input wire logic		RST_N,
	input wire spdf_cfg_s		CFG,
	input wire logic		RESET_CMD,
	input wire logic		TXD,
	input wire logic		RTS_N,
	input wire logic		NET_TX_VALID,
	input wire logic		NET_TX_READY,
	input wire logic [7:0]		NET_RX_DATA,
	input wire logic		NET_RX_VALID,
	input wire logic		NET_RX_READY,
	input wire logic [CNT_W-1:0]	FIFO_OVF_CNT,
	input wire logic		DROP_CONN
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	// Start bit and busy launched together
	sequence s_start;
		!TXD && !NET_TX_READY;
	endsequence
	a_rst_quiet: assert property ($rose(RST_N) |-> TXD && RTS_N && FIFO_OVF_CNT == '0) else $error("reset values");
	a_cmd_reset: assert property (RESET_CMD |-> ##2 TXD && !NET_TX_READY && !NET_RX_VALID) else $error("cmd reset");
	a_take_start: assert property (NET_TX_VALID && NET_TX_READY |=> s_start) else $error("no start bit");
	a_tx_idle: assert property (NET_TX_READY |-> TXD) else $error("line not idle");
	a_flow_none: assert property ($past(RST_N) && !$past(RESET_CMD) && !$past(RESET_CMD, 2) && !CFG.flow_en
		|-> !RTS_N) else $error("rts gated");
	a_drop_pulse: assert property (DROP_CONN |-> CFG.silent_en ##1 !DROP_CONN) else $error("drop pulse");
	a_rx_hold: assert property (NET_RX_VALID && !NET_RX_READY |=> NET_RX_VALID && $stable(NET_RX_DATA))
		else $error("rx not held");
	a_rx_len: assert property (NET_RX_VALID && CFG.char_len == 2'h2 |-> !NET_RX_DATA[7]) else $error("rx width");
endmodule
bind spdf_top spdf_top_properties #(.CNT_W(CNT_W)) i_spdf_top_properties (.REF_CLK(REF_CLK), .RST_N(RST_N),
	.CFG(CFG), .RESET_CMD(RESET_CMD), .TXD(TXD), .RTS_N(RTS_N), .NET_TX_VALID(NET_TX_VALID),
	.NET_TX_READY(NET_TX_READY), .NET_RX_DATA(NET_RX_DATA), .NET_RX_VALID(NET_RX_VALID),
	.NET_RX_READY(NET_RX_READY), .FIFO_OVF_CNT(FIFO_OVF_CNT), .DROP_CONN(DROP_CONN));

// file: verif/spdf_serial_peer.sv
// Purpose: Serial equipment on the far side
// Assumes: 7 data bits, even parity, two stops
// Notes:   Line rests at mark between frames
`timescale 1ns/1ps
module spdf_serial_peer #(
	parameter int BIT = 864
) (
	input wire logic	clk,
	input wire logic	txd,
	output logic		rxd
);
	initial rxd = 1'b1;
	task automatic send(input logic [7:0] b);
		logic [10:0] v;
		v = {2'b11, ^b[6:0], b[6:0], 1'b0};
		for (int k = 0; k < 11; k++) begin
			rxd = v[k];
			repeat (BIT) @(posedge clk);
			#1;
		end
	endtask
	// Mid-bit sampling tolerates a short start bit
	task automatic grab(output logic [10:0] f);
		int n;
		for (n = 0; n < 900 && txd !== 1'b0; n++) @(posedge clk);
		repeat (BIT / 2) @(posedge clk);
		#1;
		for (int k = 0; k < 11; k++) begin
			f[k] = txd;
			repeat (BIT) @(posedge clk);
			#1;
		end
	endtask
endmodule

// file: verif/spdf_top_bench.sv
// Purpose: Directed bench of spdf_top
// Assumes: 230400 bps, 7E2, delimiter 0D
// Notes:   Silent step shortened to 50 cycles
`timescale 1ns/1ps
module spdf_top_bench;
	import spdf_pkg::*;
	logic REF_CLK = 1'b0, RST_N = 1'b0, RESET_CMD = 1'b0, NET_TX_VALID = 1'b0, NET_RX_READY = 1'b0, CTS_N = 1'b0;
	logic [7:0] NET_TX_DATA = 8'h41;
	logic TXD, RTS_N, RXD, NET_TX_READY, NET_RX_VALID, DROP_CONN;
	logic [7:0] NET_RX_DATA;
	logic [31:0] MEM_OVF_CNT, FIFO_OVF_CNT;
	logic [10:0] f;
	spdf_cfg_s CFG;
	spdf_sts_s STATUS;
	int err_count = 0, comparisons = 0, i;
	always #2.5 REF_CLK = ~REF_CLK;
	spdf_top #(.SILENT_STEP_CYC(50)) i_spdf_top (.REF_CLK(REF_CLK), .RST_N(RST_N), .CFG(CFG),
		.RESET_CMD(RESET_CMD), .RXD(RXD), .CTS_N(CTS_N), .TXD(TXD), .RTS_N(RTS_N),
		.NET_TX_DATA(NET_TX_DATA), .NET_TX_VALID(NET_TX_VALID), .NET_TX_READY(NET_TX_READY),
		.NET_RX_DATA(NET_RX_DATA), .NET_RX_VALID(NET_RX_VALID), .NET_RX_READY(NET_RX_READY),
		.MEM_OVF_CNT(MEM_OVF_CNT), .FIFO_OVF_CNT(FIFO_OVF_CNT), .DROP_CONN(DROP_CONN), .STATUS(STATUS));
	spdf_serial_peer i_spdf_serial_peer (.clk(REF_CLK), .txd(TXD), .rxd(RXD));
	task automatic cyc(input int n);
		repeat (n) @(posedge REF_CLK);
		#1;
	endtask
	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	// Waits for a byte, then takes it in one cycle
	task automatic rx_take(input logic [7:0] e);
		int n;
		for (n = 0; n < 300 && NET_RX_VALID !== 1'b1; n++) cyc(1);
		chk(NET_RX_VALID === 1'b1 && NET_RX_DATA === e, "rx byte");
		NET_RX_READY = 1'b1;
		cyc(1);
		NET_RX_READY = 1'b0;
	endtask
	// Nothing may be offered in this window
	task automatic rx_none();
		logic s;
		s = 1'b0;
		repeat (400) begin
			cyc(1);
			s |= NET_RX_VALID;
		end
		chk(s === 1'b0, "unexpected rx");
	endtask
	task automatic tally_and_finish();
		if (err_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (90000) @(posedge REF_CLK);
		err_count++;
		tally_and_finish();
	end
	initial begin
		CFG = SPDF_CFG_RST;
		CFG.baud_sel = 4'hA;
		CFG.char_len = 2'h2;
		CFG.parity = SPDF_PAR_EVEN;
		CFG.stop = SPDF_STOP_2;
		CFG.delim1_en = 1'b1;
		CFG.delim1 = 8'h0D;
		CFG.silent_en = 1'b1;
		CFG.silent_steps = 8'h02;
		CFG.drop_en = 1'b1;
		cyc(8);
		RST_N = 1'b1;
		for (i = 0; i < 150 && DROP_CONN !== 1'b1; i++) cyc(1);
		chk(i >= 90 && i <= 110, "silent drop");
		for (i = 0; i < 20 && NET_TX_READY !== 1'b1; i++) cyc(1);
		NET_TX_VALID = 1'b1;
		cyc(1);
		NET_TX_VALID = 1'b0;
		i_spdf_serial_peer.grab(f);
		chk(f === {2'b11, ^NET_TX_DATA[6:0], NET_TX_DATA[6:0], 1'b0}, "tx frame");
		i_spdf_serial_peer.send(8'h55);
		rx_none();
		i_spdf_serial_peer.send(8'h0D);
		rx_take(8'h55);
		rx_none();
		// Stored only; old setting still in force
		CFG.drop_en = 1'b0;
		i_spdf_serial_peer.send(8'h44);
		i_spdf_serial_peer.send(8'h0D);
		rx_take(8'h44);
		rx_none();
		// Second delimiter only, flow control on, far side holding CTS off
		CFG.flow_en = 1'b1;
		CFG.delim1_en = 1'b0;
		CFG.delim2_en = 1'b1;
		CFG.delim2 = 8'h0D;
		CTS_N = 1'b1;
		RESET_CMD = 1'b1;
		cyc(1);
		RESET_CMD = 1'b0;
		cyc(20);
		chk(NET_TX_READY === 1'b0 && RTS_N === 1'b0, "cts pause");
		i_spdf_serial_peer.send(8'h0D);
		rx_take(8'h0D);
		CTS_N = 1'b0;
		NET_TX_DATA = 8'hBA;
		for (i = 0; i < 20 && NET_TX_READY !== 1'b1; i++) cyc(1);
		chk(NET_TX_READY === 1'b1, "cts resume");
		NET_TX_VALID = 1'b1;
		cyc(1);
		NET_TX_VALID = 1'b0;
		i_spdf_serial_peer.grab(f);
		chk(f === {2'b11, ^NET_TX_DATA[6:0], NET_TX_DATA[6:0], 1'b0}, "tx upper bits");
		chk(FIFO_OVF_CNT === '0 && MEM_OVF_CNT === '0 && STATUS === '0, "ovf count");
		tally_and_finish();
	end
endmodule
